// >>> common/bus_cmd_pkg.sv
// Purpose: Shared constants and types for the local bus command controller.
// Assumes: One system clock; two clocks per bus state.
// Notes:   Cycle codes are {space_select, status_hi_n, status_lo_n}.

package bus_cmd_pkg;

    // Decoded bus cycle codes
    localparam logic [2:0] CYC_INT_ACK  = 3'h0;
    localparam logic [2:0] CYC_IO_RD    = 3'h1;
    localparam logic [2:0] CYC_IO_WR    = 3'h2;
    localparam logic [2:0] CYC_IO_IDLE  = 3'h3;
    localparam logic [2:0] CYC_HALT     = 3'h4;
    localparam logic [2:0] CYC_MEM_RD   = 3'h5;
    localparam logic [2:0] CYC_MEM_WR   = 3'h6;
    localparam logic [2:0] CYC_MEM_IDLE = 3'h7;

    // Bit positions in the internal command vector
    localparam int CMD_MEM_RD  = 0;
    localparam int CMD_MEM_WR  = 1;
    localparam int CMD_IO_RD   = 2;
    localparam int CMD_IO_WR   = 3;
    localparam int CMD_INT_ACK = 4;
    localparam int CMD_COUNT   = 5;

    // Reset and idle levels
    localparam logic [CMD_COUNT-1:0] CMD_IDLE_N = 5'h1f;
    localparam logic                 DIR_IDLE   = 1'b1;
    localparam logic                 DIR_READ   = 1'b0;
    localparam logic                 DIR_WRITE  = 1'b1;

    // Clocks per bus state: status lasts two, command two per repeat
    localparam logic [4:0] STATUS_CLKS  = 5'h02;
    localparam logic [4:0] READY_OFFSET = 5'h03;

    // Bus states of the controller
    typedef enum logic [3:0] {
        ST_IDLE    = 4'b0001,
        ST_STATUS  = 4'b0010,
        ST_COMMAND = 4'b0100,
        ST_HALT    = 4'b1000
    } bus_state_t;

    // Host sequencer states
    typedef enum logic [2:0] {
        H_IDLE   = 3'b001,
        H_STATUS = 3'b010,
        H_WAIT   = 3'b100
    } host_state_t;

endpackage

// >>> common/bus_cmd_if.sv
// Purpose: Pins between bus master side and command controller.
// Assumes: Both ends on the same clock; grant pin may still be asynchronous.
// Notes:   Command pins are three-state; cmd_oe high means driven.

`timescale 1ns/1ps
`default_nettype none

interface bus_cmd_if;
    // Master status and selects
    logic status_hi_n;
    logic status_lo_n;
    logic space_select;
    logic command_delay;
    logic latched_select;
    logic grant_or_enable_pin;
    logic timing_mode_strap;
    logic ready_n;
    // Commands and transceiver control
    logic mem_read_cmd_n;
    logic mem_write_cmd_n;
    logic io_read_cmd_n;
    logic io_write_cmd_n;
    logic int_ack_cmd_n;
    logic cmd_oe;
    logic xcvr_enable;
    logic xcvr_direction;

    modport device (
        input  status_hi_n, status_lo_n, space_select, command_delay,
        input  latched_select, grant_or_enable_pin, timing_mode_strap, ready_n,
        output mem_read_cmd_n, mem_write_cmd_n, io_read_cmd_n, io_write_cmd_n,
        output int_ack_cmd_n, cmd_oe, xcvr_enable, xcvr_direction
    );

    modport host (
        output status_hi_n, status_lo_n, space_select, command_delay,
        output latched_select, grant_or_enable_pin, timing_mode_strap, ready_n,
        input  mem_read_cmd_n, mem_write_cmd_n, io_read_cmd_n, io_write_cmd_n,
        input  int_ack_cmd_n, cmd_oe, xcvr_enable, xcvr_direction
    );
endinterface

`default_nettype wire

// >>> rtl/bus_master_end.sv
// Purpose: Bus master end: issues status, selects, strap and ready.
// Assumes: Start is taken only while idle; strap held static by user.
// Notes:   Ready is driven low for one clock at the end of the last command state.

`timescale 1ns/1ps
`default_nettype none

module bus_master_end
    import bus_cmd_pkg::*;
(
    // Clock and reset
    input  wire logic       REF_CLK_I,
    input  wire logic       RSTN_I,
    // User request
    input  wire logic       START_I,
    input  wire logic [2:0] CYCLE_TYPE_I,
    input  wire logic [3:0] WAIT_STATES_I,
    // User pin levels
    input  wire logic       DELAY_I,
    input  wire logic       SELECT_I,
    input  wire logic       GRANT_OR_ENABLE_I,
    input  wire logic       STRAP_I,
    // User status
    output logic            BUSY_O,
    output logic            DONE_O,
    // Bus pins
    bus_cmd_if.host         BUS
);

    host_state_t state_reg;
    logic [5:0]  cnt_reg;
    logic [5:0]  target_reg;
    logic [2:0]  status_reg;
    logic        ready_n_reg;
    logic        busy_reg;
    logic        done_reg;
    logic        delay_reg;
    logic        select_reg;
    logic        grant_reg;
    logic        strap_reg;
    logic        start_ok;

    ////////////////////////////////////////////////////////////////////////////
    // Start only for real cycle codes
    assign start_ok = START_I && (state_reg == H_IDLE) &&
                      (CYCLE_TYPE_I != CYC_IO_IDLE) && (CYCLE_TYPE_I != CYC_MEM_IDLE);

    // Sequencer through status and command states
    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            state_reg   <= H_IDLE;
            cnt_reg     <= 6'h00;
            target_reg  <= 6'h00;
            status_reg  <= CYC_MEM_IDLE;
            ready_n_reg <= 1'b1;
            done_reg    <= 1'b0;
        end else begin
            done_reg    <= 1'b0;
            ready_n_reg <= 1'b1;
            cnt_reg     <= cnt_reg + 6'h01;
            unique case (state_reg)
                H_IDLE: begin
                    cnt_reg <= 6'h00;
                    if (start_ok) begin
                        state_reg  <= H_STATUS;
                        status_reg <= CYCLE_TYPE_I;
                        // One spare bit so fifteen wait states do not wrap
                        target_reg <= {1'b0, READY_OFFSET} + {1'b0, WAIT_STATES_I, 1'b0};
                    end
                end
                H_STATUS: begin
                    if (cnt_reg == {1'b0, STATUS_CLKS} - 6'h01) begin
                        status_reg[1:0] <= 2'h3;
                        if (status_reg == CYC_HALT) begin
                            state_reg <= H_IDLE;
                            done_reg  <= 1'b1;
                        end else begin
                            state_reg <= H_WAIT;
                        end
                    end
                end
                H_WAIT: begin
                    if (cnt_reg == target_reg) begin
                        ready_n_reg <= 1'b0;
                        state_reg   <= H_IDLE;
                        done_reg    <= 1'b1;
                    end
                end
            endcase
        end
    end

    // Static pin levels from user; strap meant to stay fixed
    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            delay_reg  <= 1'b0;
            select_reg <= 1'b1;
            grant_reg  <= 1'b1;
            strap_reg  <= 1'b0;
        end else begin
            delay_reg  <= DELAY_I;
            select_reg <= SELECT_I;
            grant_reg  <= GRANT_OR_ENABLE_I;
            strap_reg  <= STRAP_I;
        end
    end

    // Busy flag
    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            busy_reg <= 1'b0;
        end else begin
            busy_reg <= start_ok || (busy_reg && !done_reg && state_reg != H_IDLE);
        end
    end

    assign BUS.space_select        = status_reg[2];
    assign BUS.status_hi_n         = status_reg[1];
    assign BUS.status_lo_n         = status_reg[0];
    assign BUS.ready_n             = ready_n_reg;
    assign BUS.command_delay       = delay_reg;
    assign BUS.latched_select      = select_reg;
    assign BUS.grant_or_enable_pin = grant_reg;
    assign BUS.timing_mode_strap   = strap_reg;
    assign BUSY_O                  = busy_reg;
    assign DONE_O                  = done_reg;

endmodule

`default_nettype wire

// >>> rtl/bus_cmd_device.sv
// Purpose: Command and transceiver control generator for the local bus.
// Assumes: Status, selects, delay and ready come from same-clock logic.
// Notes:   Grant/enable pin and strap pass two flip-flops before use.

`timescale 1ns/1ps
`default_nettype none

module bus_cmd_device
    import bus_cmd_pkg::*;
(
    // Clock and reset
    input  wire logic       REF_CLK_I,
    input  wire logic       RSTN_I,
    // User status
    output logic            BUSY_O,
    output logic            CMD_ACTIVE_O,
    output logic [2:0]      CYCLE_TYPE_O,
    // Bus pins
    bus_cmd_if.device       BUS
);

    bus_state_t           state_reg;
    bus_state_t           state_next;
    logic                 phase_reg;
    logic                 phase_next;
    logic [2:0]           cyc_reg;
    logic [2:0]           cyc_next;
    logic                 sel_reg;
    logic                 sel_next;
    logic                 dly_reg;
    logic                 dly_next;
    logic [CMD_COUNT-1:0] cmd_n_reg;
    logic [CMD_COUNT-1:0] cmd_n_next;
    logic                 oe_reg;
    logic                 oe_next;
    logic                 xen_reg;
    logic                 xen_next;
    logic                 dir_reg;
    logic                 dir_next;
    logic                 busy_reg;
    logic                 cmd_active_reg;
    logic                 grant_meta_reg;
    logic                 grant_sync_reg;
    logic                 strap_meta_reg;
    logic                 strap_sync_reg;
    logic [2:0]           code_now;
    logic                 stat_low;
    logic                 new_cycle;
    logic                 enabled;
    logic                 timing_ok;
    logic                 delay_ok;
    logic                 in_cmd_next;

    ////////////////////////////////////////////////////////////////////////////
    // Cycle type helpers

    function automatic logic is_write(input logic [2:0] c);
        is_write = (c == CYC_IO_WR) || (c == CYC_MEM_WR);
    endfunction

    function automatic logic is_read(input logic [2:0] c);
        is_read = (c == CYC_IO_RD) || (c == CYC_MEM_RD) || (c == CYC_INT_ACK);
    endfunction

    function automatic logic is_idle_code(input logic [2:0] c);
        is_idle_code = (c == CYC_IO_IDLE) || (c == CYC_MEM_IDLE);
    endfunction

    // Command vector with the one line for this cycle type low
    function automatic logic [CMD_COUNT-1:0] cmd_for(input logic [2:0] c);
        logic [CMD_COUNT-1:0] v;
        v = CMD_IDLE_N;
        unique case (c)
            CYC_MEM_RD:  v[CMD_MEM_RD]  = 1'b0;
            CYC_MEM_WR:  v[CMD_MEM_WR]  = 1'b0;
            CYC_IO_RD:   v[CMD_IO_RD]   = 1'b0;
            CYC_IO_WR:   v[CMD_IO_WR]   = 1'b0;
            CYC_INT_ACK: v[CMD_INT_ACK] = 1'b0;
            default:     v = CMD_IDLE_N;
        endcase
        cmd_for = v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Two-stage synchronisers for the pin and the strap

    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            grant_meta_reg <= 1'b0;
            grant_sync_reg <= 1'b0;
            strap_meta_reg <= 1'b0;
            strap_sync_reg <= 1'b0;
        end else begin
            grant_meta_reg <= BUS.grant_or_enable_pin;
            grant_sync_reg <= grant_meta_reg;
            strap_meta_reg <= BUS.timing_mode_strap;
            strap_sync_reg <= strap_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Decode and gating terms

    assign code_now  = {BUS.space_select, BUS.status_hi_n, BUS.status_lo_n};
    assign stat_low  = !BUS.status_hi_n || !BUS.status_lo_n;
    assign new_cycle = stat_low && !is_idle_code(code_now);
    // Strap high: pin is active-low grant; strap low: active-high enable
    assign enabled   = strap_sync_reg ? !grant_sync_reg : grant_sync_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Bus state sequencing

    always_comb begin
        state_next = state_reg;
        phase_next = !phase_reg;
        unique case (state_reg)
            ST_IDLE: begin
                phase_next = 1'b0;
                if (new_cycle) begin
                    state_next = ST_STATUS;
                end
            end
            ST_STATUS: begin
                if (phase_reg) begin
                    state_next = (cyc_reg == CYC_HALT) ? ST_HALT : ST_COMMAND;
                end
            end
            ST_COMMAND: begin
                // Ready high at end of command state gives a wait state
                if (phase_reg && !BUS.ready_n) begin
                    state_next = new_cycle ? ST_STATUS : ST_IDLE;
                end
            end
            ST_HALT: begin
                phase_next = 1'b0;
                if (new_cycle) begin
                    state_next = ST_STATUS;
                end
            end
        endcase
    end

    // Cycle type, select and delay bookkeeping
    always_comb begin
        cyc_next = cyc_reg;
        sel_next = sel_reg;
        dly_next = dly_reg;
        if (state_next == ST_STATUS && state_reg != ST_STATUS) begin
            cyc_next = code_now;
            sel_next = BUS.latched_select;
            dly_next = 1'b0;
        end else if (state_next == ST_COMMAND && !BUS.command_delay) begin
            dly_next = 1'b1;
        end
    end

    assign in_cmd_next = (state_next == ST_COMMAND);
    // Delay sampled each command clock; first low sample releases the command
    assign delay_ok    = dly_reg || (in_cmd_next && !BUS.command_delay);
    // Standard-compatible timing holds off the first command clock
    assign timing_ok   = !strap_sync_reg || (state_reg == ST_COMMAND);

    ////////////////////////////////////////////////////////////////////////////
    // Output next values

    always_comb begin
        cmd_n_next = CMD_IDLE_N;
        if (in_cmd_next && sel_next && enabled && delay_ok && timing_ok) begin
            cmd_n_next = cmd_for(cyc_next);
        end
        // Commands float only without grant in standard mode
        oe_next = !(strap_sync_reg && grant_sync_reg);
        xen_next = in_cmd_next && sel_next && enabled &&
                   (!is_write(cyc_next) || timing_ok);
        // Direction from decoded type only, moved while enable is low
        if (xen_reg) begin
            dir_next = dir_reg;
        end else if ((state_next == ST_STATUS || in_cmd_next) && is_read(cyc_next)) begin
            dir_next = DIR_READ;
        end else if ((state_next == ST_STATUS || in_cmd_next) && is_write(cyc_next)) begin
            dir_next = DIR_WRITE;
        end else begin
            dir_next = DIR_IDLE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State registers

    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            state_reg <= ST_IDLE;
            phase_reg <= 1'b0;
            cyc_reg   <= CYC_MEM_IDLE;
            sel_reg   <= 1'b0;
            dly_reg   <= 1'b0;
        end else begin
            state_reg <= state_next;
            phase_reg <= phase_next;
            cyc_reg   <= cyc_next;
            sel_reg   <= sel_next;
            dly_reg   <= dly_next;
        end
    end

    // Pin output registers
    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            cmd_n_reg <= CMD_IDLE_N;
            oe_reg    <= 1'b1;
            xen_reg   <= 1'b0;
            dir_reg   <= DIR_IDLE;
            cmd_active_reg <= 1'b0;
        end else begin
            cmd_n_reg <= cmd_n_next;
            oe_reg    <= oe_next;
            xen_reg   <= xen_next;
            dir_reg   <= dir_next;
            cmd_active_reg <= (cmd_n_next != CMD_IDLE_N);
        end
    end

    // User busy flag
    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            busy_reg <= 1'b0;
        end else begin
            busy_reg <= (state_next == ST_STATUS) || in_cmd_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin and user connections

    assign BUS.mem_read_cmd_n  = cmd_n_reg[CMD_MEM_RD];
    assign BUS.mem_write_cmd_n = cmd_n_reg[CMD_MEM_WR];
    assign BUS.io_read_cmd_n   = cmd_n_reg[CMD_IO_RD];
    assign BUS.io_write_cmd_n  = cmd_n_reg[CMD_IO_WR];
    assign BUS.int_ack_cmd_n   = cmd_n_reg[CMD_INT_ACK];
    assign BUS.cmd_oe          = oe_reg;
    assign BUS.xcvr_enable     = xen_reg;
    assign BUS.xcvr_direction  = dir_reg;
    assign BUSY_O              = busy_reg;
    assign CMD_ACTIVE_O        = cmd_active_reg;
    assign CYCLE_TYPE_O        = cyc_reg;

endmodule

`default_nettype wire

// >>> verif/bus_cmd_checker.sv
// Purpose: Pin-level checks on the link between bus master end and controller.
// Assumes: One clock; strap and grant pin pass a two-stage synchroniser.
// Notes:   Takes the interface signals as plain inputs.

`timescale 1ns/1ps
`default_nettype none

module bus_cmd_checker (
    // Clock and reset
    input wire logic REF_CLK_I,
    input wire logic RSTN_I,
    // Master side pins
    input wire logic command_delay,
    input wire logic grant_or_enable_pin,
    input wire logic timing_mode_strap,
    input wire logic ready_n,
    // Controller side pins
    input wire logic mem_read_cmd_n,
    input wire logic mem_write_cmd_n,
    input wire logic io_read_cmd_n,
    input wire logic io_write_cmd_n,
    input wire logic int_ack_cmd_n,
    input wire logic cmd_oe,
    input wire logic xcvr_enable,
    input wire logic xcvr_direction
);
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!RSTN_I);

    // All five command lines as one vector
    logic [4:0] cmds_n;
    assign cmds_n = {int_ack_cmd_n, io_write_cmd_n, io_read_cmd_n, mem_write_cmd_n, mem_read_cmd_n};

    // Grant or enable held long enough to pass the synchroniser
    sequence float_req;
        (timing_mode_strap && grant_or_enable_pin) [*4];
    endsequence
    sequence drive_req;
        (timing_mode_strap && !grant_or_enable_pin) [*4];
    endsequence
    sequence off_req;
        (!timing_mode_strap && !grant_or_enable_pin) [*5];
    endsequence

    one_command_a: assert property ($countones(~cmds_n) <= 1)
        else $error("more than one command line low");
    reset_idle_a: assert property ($rose(RSTN_I) |-> &cmds_n && !xcvr_enable && xcvr_direction)
        else $error("outputs not idle after reset");
    delay_hold_a: assert property (&cmds_n && command_delay |=> &cmds_n)
        else $error("command started while delay high");
    ready_end_a: assert property (!ready_n |=> &cmds_n && !xcvr_enable)
        else $error("cycle not ended by ready");
    cmd_release_a: assert property ($rose(&cmds_n) |-> !$past(ready_n))
        else $error("command released without ready");
    dir_change_a: assert property ($changed(xcvr_direction) |-> !xcvr_enable && !$past(xcvr_enable))
        else $error("direction moved with transceiver enabled");
    dir_read_a: assert property (!mem_read_cmd_n || !io_read_cmd_n || !int_ack_cmd_n |-> !xcvr_direction)
        else $error("direction high during read command");
    dir_write_a: assert property (!mem_write_cmd_n || !io_write_cmd_n |-> xcvr_direction)
        else $error("direction low during write command");
    float_off_a: assert property (float_req |-> !cmd_oe && !xcvr_enable)
        else $error("commands driven without grant");
    grant_drive_a: assert property (drive_req |-> cmd_oe)
        else $error("commands floating with grant");
    forced_off_a: assert property (off_req |-> cmd_oe && &cmds_n && !xcvr_enable)
        else $error("enable low did not force outputs inactive");
endmodule

`default_nettype wire

// >>> verif/test_local_bus_command_controller.sv
// Purpose: Runs bus cycles from the master end through the command controller.
// Assumes: Levels settle six clocks before each start; pins sampled at falling edge.
// Notes:   Inputs driven at rising edges by non-blocking assignment.

`timescale 1ns/1ps
`default_nettype none

module test_local_bus_command_controller
    import bus_cmd_pkg::*;
;
    logic       ref_clk = 1'b0;
    logic       rstn, start, dly, sel, gate_pin, strap;
    logic [2:0] code, d_type;
    logic [3:0] waits;
    logic       m_busy, m_done, d_busy, d_act;
    logic [4:0] cmds_n;
    int         errors = 0;
    int         check_count = 0;
    int         cycles = 0;
    logic [2:0] codes [5] = '{CYC_INT_ACK, CYC_IO_RD, CYC_IO_WR, CYC_MEM_RD, CYC_MEM_WR};

    bus_cmd_if bus ();

    assign cmds_n = {bus.int_ack_cmd_n, bus.io_write_cmd_n, bus.io_read_cmd_n,
                     bus.mem_write_cmd_n, bus.mem_read_cmd_n};

    // Both ends and the pin checker
    bus_master_end bus_master_end_i (
        .REF_CLK_I(ref_clk), .RSTN_I(rstn), .START_I(start), .CYCLE_TYPE_I(code),
        .WAIT_STATES_I(waits), .DELAY_I(dly), .SELECT_I(sel), .GRANT_OR_ENABLE_I(gate_pin),
        .STRAP_I(strap), .BUSY_O(m_busy), .DONE_O(m_done), .BUS(bus.host));
    bus_cmd_device bus_cmd_device_i (
        .REF_CLK_I(ref_clk), .RSTN_I(rstn), .BUSY_O(d_busy), .CMD_ACTIVE_O(d_act),
        .CYCLE_TYPE_O(d_type), .BUS(bus.device));
    bus_cmd_checker bus_cmd_checker_i (
        .REF_CLK_I(ref_clk), .RSTN_I(rstn), .command_delay(bus.command_delay),
        .grant_or_enable_pin(bus.grant_or_enable_pin), .timing_mode_strap(bus.timing_mode_strap),
        .ready_n(bus.ready_n), .mem_read_cmd_n(bus.mem_read_cmd_n),
        .mem_write_cmd_n(bus.mem_write_cmd_n), .io_read_cmd_n(bus.io_read_cmd_n),
        .io_write_cmd_n(bus.io_write_cmd_n), .int_ack_cmd_n(bus.int_ack_cmd_n),
        .cmd_oe(bus.cmd_oe), .xcvr_enable(bus.xcvr_enable), .xcvr_direction(bus.xcvr_direction));

    // Clock and hang guard
    always #25 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errors++;
            report_and_stop;
        end
    end

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d, mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Command line expected low for each cycle code
    function automatic logic [4:0] cmd_bit(input logic [2:0] c);
        case (c)
            CYC_MEM_RD:  cmd_bit = 5'h01 << CMD_MEM_RD;
            CYC_MEM_WR:  cmd_bit = 5'h01 << CMD_MEM_WR;
            CYC_IO_RD:   cmd_bit = 5'h01 << CMD_IO_RD;
            CYC_IO_WR:   cmd_bit = 5'h01 << CMD_IO_WR;
            CYC_INT_ACK: cmd_bit = 5'h01 << CMD_INT_ACK;
            default:     cmd_bit = 5'h00;
        endcase
    endfunction

    // One bus cycle; dclk is clocks of delay high after start, 99 for all of it
    task automatic run(input logic [2:0] c, input logic [3:0] w, input int dclk,
                       input logic s, input logic ok, input logic st);
        logic [4:0] mask;
        logic       go, en_seen, oe_low, dir_low, act_seen, busy_seen;
        int         lat;
        mask = 5'h00;
        en_seen = 1'b0;
        oe_low = 1'b0;
        dir_low = 1'b0;
        act_seen = 1'b0;
        busy_seen = 1'b0;
        lat = -1;
        go = s && ok && dclk != 99;
        @(posedge ref_clk);
        code <= c;
        waits <= w;
        sel <= s;
        strap <= st;
        dly <= (dclk != 0);
        gate_pin <= st ? !ok : ok;
        repeat (6) @(posedge ref_clk);
        start <= 1'b1;
        @(posedge ref_clk);
        start <= 1'b0;
        for (int n = 0; n < 40; n++) begin
            @(negedge ref_clk);
            mask = mask | ~cmds_n;
            en_seen = en_seen | bus.xcvr_enable;
            oe_low = oe_low | !bus.cmd_oe;
            dir_low = dir_low | !bus.xcvr_direction;
            act_seen = act_seen | d_act;
            busy_seen = busy_seen | (m_busy & d_busy);
            if (m_done === 1'b1 && lat < 0) lat = n;
            @(posedge ref_clk);
            if (n + 1 == dclk) dly <= 1'b0;
        end
        dly <= 1'b0;
        // Look at settled outputs, away from the launching edge
        @(negedge ref_clk);
        check("command lines", {3'h0, go ? cmd_bit(c) : 5'h00}, {3'h0, mask});
        check("command active", {7'h0, go && cmd_bit(c) != 0}, {7'h0, act_seen});
        check("xcvr enable", {7'h0, s && ok && cmd_bit(c) != 0}, {7'h0, en_seen});
        check("float seen", {7'h0, st && !ok}, {7'h0, oe_low});
        check("read direction", {7'h0, c inside {CYC_INT_ACK, CYC_IO_RD, CYC_MEM_RD}},
              {7'h0, dir_low});
        check("done latency", (c == CYC_HALT) ? 8'h02 : 8'h04 + 8'(2 * w), lat[7:0]);
        check("idle direction", 8'h01, {7'h0, bus.xcvr_direction});
        check("cycle type", {5'h0, c}, {5'h0, d_type});
        check("busy seen", 8'h01, {7'h0, busy_seen});
        check("busy idle", 8'h00, {6'h0, m_busy, d_busy});
    endtask

    // Reset, then the five command codes in both modes, then halt, refusals and hold-offs
    initial begin
        rstn = 1'b0;
        start = 1'b0;
        code = 3'h7;
        waits = 4'h0;
        dly = 1'b0;
        sel = 1'b1;
        gate_pin = 1'b1;
        strap = 1'b0;
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        @(negedge ref_clk);
        check("reset commands", 8'h1f, {3'h0, cmds_n});
        check("reset xcvr", 8'h01, {6'h0, bus.xcvr_enable, bus.xcvr_direction});
        check("reset cycle type", 8'h07, {5'h0, d_type});
        for (int m = 0; m < 2; m++) begin
            for (int i = 0; i < 5; i++) begin
                run(codes[i], 4'h1, 0, 1'b1, 1'b1, m[0]);
            end
        end
        run(CYC_HALT, 4'h0, 0, 1'b1, 1'b1, 1'b0);
        run(CYC_MEM_RD, 4'h0, 0, 1'b0, 1'b1, 1'b0);
        run(CYC_IO_WR, 4'h1, 0, 1'b1, 1'b0, 1'b0);
        run(CYC_MEM_WR, 4'h1, 0, 1'b1, 1'b0, 1'b1);
        run(CYC_IO_RD, 4'h2, 99, 1'b1, 1'b1, 1'b0);
        run(CYC_MEM_RD, 4'h3, 3, 1'b1, 1'b1, 1'b0);
        run(CYC_MEM_WR, 4'h0, 0, 1'b1, 1'b1, 1'b0);
        run(CYC_INT_ACK, 4'h2, 0, 1'b1, 1'b1, 1'b1);
        report_and_stop;
    end
endmodule

`default_nettype wire
